// File: sac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// host serial master
// ****************
module sac_host_model
(
    // link pins
    output var logic select_n,
    output var logic shift_clk,
    output var logic serial_in,
    input wire logic serial_out,
    input wire logic conversion_strobe
);
    logic [7:0] strobe_seen;

    initial
    begin
        select_n = 1'b1;
        shift_clk = 1'b0;
        serial_in = 1'b0;
        strobe_seen = 8'h00;
    end

    // idle data line never shows a stale level; wait covers pin sync
    task automatic sel(input logic level);
        select_n <= level;
        serial_in <= ~serial_in;
        #250;
    endtask : sel

    // mode zero byte, msb first; clock rests low between bytes
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            serial_in <= tx[i];
            #62.5;
            rx[i] = serial_out;
            strobe_seen[i] = conversion_strobe;
            shift_clk <= 1'b1;
            #62.5;
            shift_clk <= 1'b0;
        end
    endtask : xfer
endmodule : sac_host_model
`default_nettype wire

// File: sac_map.svh
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
// Functional notes
// - result sits in bytes two and three, two zeros before, six after
// - unipolar gives straight binary, bipolar gives two's complement
// - serial output changes on falling shift edges, msb first
// - clock-mode bit picks conversion clock; shift clock always moves data
// - external mode: strobe high two shift periods after last control bit
// - external mode: one decision per clock on next eight falls, then zeros
// - external mode: select high floats outputs; strobe low after select falls
// - internal mode: strobe low at start, high at end, about 25us
// - internal mode: result held; msb on second fall after strobe rises
// - internal mode: select high blocks input, floats output, strobe driven
// - select fall starts nothing; first one bit is the control msb
// - conversion begins on the fall after the eighth control bit
// - start accepted when idle or after msb of running conversion shown
// - select toggled mid-conversion: next start bit aborts and restarts
// - back-to-back external conversions need at least ten shift clocks
// - power-on: internal mode, strobe high, zeros out until a conversion
// - control byte: start, channel 6-4, polarity, input config, power, mode
// - clock-mode bit one is external clock, zero is internal clock
// - with select low each rising shift edge captures one input bit

// register offsets
`define SAC_LEVEL_OFF 12'h000
`define SAC_STATUS_OFF 12'h004
// field positions
`define SAC_LEVEL_LSB 0
`define SAC_RES_LSB 0
`define SAC_BUSY_BIT 8
`define SAC_EXT_BIT 9
`define SAC_CTLB_LSB 16
// reset values
`define SAC_LEVEL_RST 8'h80
`define SAC_CTL_RST 8'h00
// timing
`define SAC_CLK_NS 5
`define SAC_INT_CONV_NS 25000
`define SAC_CTL_BITS 4'h8
`define SAC_RES_BITS 8
`endif

// File: sac_pkg.sv
package sac_pkg;

    typedef enum logic [1:0] {st_idle, st_ext, st_int} sac_state_t;

    typedef struct packed {
        logic start;
        logic [2:0] channel;
        logic unipolar;
        logic single_ended;
        logic power_bit;
        logic clock_mode_bit;
    } sac_ctl_t;

    typedef struct packed {
        logic [7:0] ctl;
        logic ext;
        logic busy;
        logic [7:0] result;
    } sac_status_t;

endpackage : sac_pkg

// File: sac_serial_adc.sv
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sac_map.svh"

module sac_serial_adc
    import sac_pkg::*;
#(
    parameter int CONV_CYCLES = `SAC_INT_CONV_NS / `SAC_CLK_NS
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // serial link pins
    input wire logic select_n,
    input wire logic shift_clk,
    input wire logic serial_in,
    input wire logic shutdown_n,
    output logic serial_out,
    output logic serial_out_oe,
    output logic conversion_strobe,
    output logic strobe_oe
);

    localparam int STEP = CONV_CYCLES / `SAC_RES_BITS;
    localparam int SW = $clog2(STEP + 1);
    localparam int INT_LAST = STEP * `SAC_RES_BITS - 1;

    generate
        if (CONV_CYCLES < `SAC_RES_BITS)
        begin : g_chk
            $error("CONV_CYCLES must cover eight decisions");
        end
    endgenerate

    // ****************************************
    // reset release
    // ****************************************
    logic rst_q1;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    // pins are async to ref_clk; edges are found past the second stage
    logic [3:0] pin_m;
    logic [3:0] pin_s;
    logic sclk_d;
    logic sel_d;
    logic sclk_s;
    logic sel_s;
    logic din_s;
    logic shutdown_n_s;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_rise;
    logic sel_fall;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // idle pin levels, so no false shift or select edge follows reset
            pin_m <= 4'ha;
            pin_s <= 4'ha;
            sclk_d <= 1'b0;
            sel_d <= 1'b1;
        end
        else
        begin
            pin_m <= {shutdown_n, serial_in, select_n, shift_clk};
            pin_s <= pin_m;
            sclk_d <= pin_s[0];
            sel_d <= pin_s[1];
        end
    end

    assign sclk_s = pin_s[0];
    assign sel_s = pin_s[1];
    assign din_s = pin_s[2];
    assign shutdown_n_s = pin_s[3];
    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;
    assign sel_rise = sel_s & ~sel_d;
    assign sel_fall = ~sel_s & sel_d;

    // ****************************************
    // apb registers
    // ****************************************
    logic [7:0] level;
    logic [7:0] result;
    sac_ctl_t ctl;
    sac_state_t state;
    sac_status_t status;
    logic hit;

    assign status = '{ctl: ctl, ext: ctl.clock_mode_bit,
                      busy: state != st_idle, result: result};

    always_comb
    begin
        hit = 1'b0;
        if (paddr == `SAC_LEVEL_OFF)
        begin
            hit = 1'b1;
        end
        else if (paddr == `SAC_STATUS_OFF)
        begin
            hit = 1'b1;
        end
    end

    assign pready = psel & penable;
    assign pslverr = psel & penable & ~hit;

    // level stands in for the held analog input
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            level <= `SAC_LEVEL_RST;
        end
        else if (psel && penable && pwrite && paddr == `SAC_LEVEL_OFF)
        begin
            level <= pwdata[`SAC_LEVEL_LSB +: 8];
        end
    end

    // read data is staged in the setup cycle so access needs no wait
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable)
        begin
            if (pwrite)
            begin
                prdata <= 32'h0000_0000;
            end
            else if (paddr == `SAC_LEVEL_OFF)
            begin
                prdata <= {24'h00_0000, level};
            end
            else if (paddr == `SAC_STATUS_OFF)
            begin
                prdata <= {8'h00, status.ctl, 6'h00, status.ext,
                           status.busy, status.result};
            end
            else
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ****************************************
    // control byte capture
    // ****************************************
    logic [3:0] rx_cnt;
    logic [7:0] rx_sh;
    logic msb_shown;
    logic sel_tog;
    logic start_ok;
    logic launch;

    assign start_ok = (state == st_idle) | msb_shown | sel_tog;
    assign launch = sclk_fall & (rx_cnt == `SAC_CTL_BITS) & shutdown_n_s;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_cnt <= 4'h0;
            rx_sh <= 8'h00;
        end
        else if (sel_s || !shutdown_n_s || launch)
        begin
            rx_cnt <= 4'h0;
        end
        else if (sclk_rise && rx_cnt == 4'h0)
        begin
            if (din_s && start_ok)
            begin
                rx_sh <= 8'h01;
                rx_cnt <= 4'h1;
            end
        end
        else if (sclk_rise && rx_cnt < `SAC_CTL_BITS)
        begin
            rx_sh <= {rx_sh[6:0], din_s};
            rx_cnt <= rx_cnt + 4'h1;
        end
    end

    // a toggle of select lets the next start bit restart the converter
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_tog <= 1'b0;
        end
        else if (sel_rise)
        begin
            sel_tog <= 1'b1;
        end
        else if (launch)
        begin
            sel_tog <= 1'b0;
        end
    end

    // ****************************************
    // successive approximation
    // ****************************************
    logic [7:0] sample;
    logic [7:0] sar;
    logic [7:0] mask;
    logic [7:0] trial;
    logic [7:0] next_sar;
    logic [7:0] coded;
    logic keep;
    logic decide;
    logic ext_wait;
    logic [SW-1:0] step_cnt;
    logic [7:0] out_sh;
    logic out_skip;
    logic done;

    assign trial = sar | mask;
    assign keep = sample >= trial;
    assign next_sar = keep ? trial : sar;
    assign coded = {next_sar[7] ^ ~ctl.unipolar, next_sar[6:0]};
    assign done = decide & mask[0];

    always_comb
    begin
        decide = 1'b0;
        case (state)
            st_ext:
                decide = sclk_fall & ~ext_wait;
            st_int:
                decide = step_cnt == SW'(STEP - 1);
            default:
                decide = 1'b0;
        endcase
    end

    // state and decision registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= st_idle;
            ctl <= `SAC_CTL_RST;
            sample <= 8'h00;
            sar <= 8'h00;
            mask <= 8'h80;
            ext_wait <= 1'b0;
            step_cnt <= '0;
            result <= 8'h00;
        end
        else if (!shutdown_n_s)
        begin
            state <= st_idle;
        end
        else if (launch)
        begin
            ctl <= rx_sh;
            sample <= level;
            sar <= 8'h00;
            mask <= 8'h80;
            ext_wait <= 1'b1;
            step_cnt <= '0;
            state <= rx_sh[0] ? st_ext : st_int;
        end
        else
        begin
            if (state == st_ext && sclk_fall)
            begin
                ext_wait <= 1'b0;
            end
            if (state == st_int)
            begin
                step_cnt <= decide ? '0 : step_cnt + SW'(1);
            end
            if (decide)
            begin
                sar <= next_sar;
                mask <= {1'b0, mask[7:1]};
            end
            if (done)
            begin
                result <= coded;
                state <= st_idle;
            end
        end
    end

    // ****************************************
    // strobe
    // ****************************************
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            conversion_strobe <= 1'b1;
        end
        else if (launch)
        begin
            conversion_strobe <= rx_sh[0];
        end
        else if (state == st_ext && decide && mask[7])
        begin
            conversion_strobe <= 1'b0;
        end
        else if (state == st_int && done)
        begin
            conversion_strobe <= 1'b1;
        end
        else if (ctl.clock_mode_bit && sel_fall)
        begin
            conversion_strobe <= 1'b0;
        end
    end

    // ****************************************
    // serial output
    // ****************************************
    // only the shift clock moves bits, so a slow host never misses one
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serial_out <= 1'b0;
            out_sh <= 8'h00;
            out_skip <= 1'b0;
            msb_shown <= 1'b0;
        end
        else if (launch)
        begin
            out_sh <= 8'h00;
            msb_shown <= 1'b0;
            serial_out <= 1'b0;
        end
        else if (state == st_int && done)
        begin
            out_sh <= coded;
            out_skip <= 1'b1;
        end
        else if (state == st_ext && decide)
        begin
            serial_out <= keep ^ (mask[7] & ~ctl.unipolar);
            msb_shown <= 1'b1;
        end
        else if (sclk_fall && !sel_s && state == st_idle)
        begin
            if (out_skip)
            begin
                out_skip <= 1'b0;
                serial_out <= 1'b0;
            end
            else
            begin
                serial_out <= out_sh[7];
                out_sh <= {out_sh[6:0], 1'b0};
            end
        end
        else if (sclk_fall)
        begin
            serial_out <= 1'b0;
        end
    end

    assign serial_out_oe = ~sel_s;
    assign strobe_oe = ctl.clock_mode_bit ? ~sel_s : 1'b1;

    // ****************************************
    // checks
    // ****************************************
    logic [SW+3:0] int_age;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_age <= '0;
        end
        else
        begin
            int_age <= (state == st_int && !launch) ? int_age + 1'b1 : '0;
        end
    end

    a_strobe_ext_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        launch && rx_sh[0] |=> conversion_strobe && state == st_ext)
        else $error("external strobe not raised at launch");

    a_strobe_int_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        launch && !rx_sh[0] |=> !conversion_strobe && state == st_int)
        else $error("internal strobe not lowered at launch");

    a_int_conv_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == st_int && done |-> int_age == INT_LAST)
        else $error("internal conversion length wrong");

    a_dout_on_fall: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(serial_out) |-> $past(sclk_fall))
        else $error("serial output moved off a falling edge");

    a_select_float: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sel_s |-> !serial_out_oe && (strobe_oe == !ctl.clock_mode_bit))
        else $error("outputs not floated with select high");

    a_input_blocked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sel_s ##1 sel_s |-> rx_cnt == 4'h0)
        else $error("input taken while select high");

    a_start_bit_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rx_cnt == 4'h1 && $past(rx_cnt) == 4'h0 |-> $past(din_s) && $past(sclk_rise))
        else $error("start taken without a one bit");

    a_launch_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
        launch |=> ctl == $past(rx_sh) && rx_cnt == 4'h0 && sample == $past(level))
        else $error("control byte not taken at launch");

    a_ext_msb_delay: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == st_ext && decide && mask[7] |=> !conversion_strobe && msb_shown)
        else $error("strobe not dropped when the msb went out");

    a_shutdown_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !shutdown_n_s |=> state == st_idle && rx_cnt == 4'h0)
        else $error("shutdown did not stop the converter");

endmodule : sac_serial_adc

`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sac_pkg::*;
;
    // long enough that a select toggle lands mid-conversion
    localparam int CONV = 512;
    logic ref_clk;
    logic reset_n;
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic select_n;
    logic shift_clk;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe;
    logic conversion_strobe;
    logic strobe_oe;
    logic shutdown_n;
    logic [31:0] rd;
    logic [7:0] rb1;
    logic [7:0] rb2;
    logic [7:0] rb3;
    logic [7:0] lv;
    logic [7:0] ctl;
    logic e;
    int err_total;
    int checks_done;
    int low_len;
    int n;

    sac_serial_adc #(.CONV_CYCLES(CONV)) uut (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .select_n(select_n),
        .shift_clk(shift_clk),
        .serial_in(serial_in),
        .shutdown_n(shutdown_n),
        .serial_out(serial_out),
        .serial_out_oe(serial_out_oe),
        .conversion_strobe(conversion_strobe),
        .strobe_oe(strobe_oe)
    );

    sac_host_model host (
        .select_n(select_n),
        .shift_clk(shift_clk),
        .serial_in(serial_in),
        .serial_out(serial_out),
        .conversion_strobe(conversion_strobe)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
        if (conversion_strobe === 1'b0)
            low_len <= low_len + 1;

    // ****************
    // tasks
    // ****************
    task automatic results;
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv, output logic err);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            err_total++;
            results();
        end
    endtask : apb

    // 24-clock external conversion; pre marks the first external one, right after the internal conversion
    task automatic ext_conv(input logic [7:0] l, input logic [7:0] c,
                            input logic [7:0] code, input logic pre);
        apb(1'b1, 12'h000, {24'h0, l}, rd, e);
        host.sel(1'b0);
        cmp({30'h0, strobe_oe, conversion_strobe}, {30'h0, 1'b1, pre});
        if (pre)
        begin
            host.xfer(8'h00, rb1);
            cmp({24'h0, rb1}, 32'h0);
        end
        host.xfer(c, rb1);
        host.xfer(8'h00, rb2);
        cmp({24'h0, host.strobe_seen}, 32'hc0);
        host.xfer(8'h00, rb3);
        host.sel(1'b1);
        cmp({16'h0, rb2, rb3}, {16'h0, 2'b00, code, 6'h00});
        cmp({30'h0, serial_out_oe, strobe_oe}, 32'h0);
        apb(1'b0, 12'h004, 32'h0, rd, e);
        cmp(rd, {8'h00, c, 6'h00, 2'b10, code});
    endtask : ext_conv

    // ****************
    // main sequence
    // ****************
    initial
    begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        shutdown_n = 1'b1;
        err_total = 0;
        checks_done = 0;
        low_len = 0;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        cmp({30'h0, strobe_oe, conversion_strobe}, 32'h3);
        apb(1'b0, 12'h000, 32'h0, rd, e);
        cmp(rd, 32'h80);
        apb(1'b1, 12'h004, 32'hffffffff, rd, e);
        apb(1'b0, 12'h004, 32'h0, rd, e);
        cmp(rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0, rd, e);
        cmp({rd[30:0], e}, 32'h1);
        // internal clock conversion first, while the strobe still rests high
        apb(1'b1, 12'h000, 32'h5c, rd, e);
        host.sel(1'b0);
        host.xfer(8'hae, rb1);
        low_len = 0;
        #100;
        cmp({31'h0, conversion_strobe}, 32'h0);
        host.sel(1'b1);
        cmp({30'h0, strobe_oe, serial_out_oe}, 32'h2);
        apb(1'b0, 12'h004, 32'h0, rd, e);
        cmp({30'h0, rd[9:8]}, 32'h1);
        n = 0;
        while (conversion_strobe !== 1'b1 && n < 4000)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (conversion_strobe !== 1'b1)
        begin
            err_total++;
            results();
        end
        cmp(low_len, 8 * (CONV / 8));
        host.sel(1'b0);
        host.xfer(8'h00, rb2);
        host.xfer(8'h00, rb3);
        cmp({16'h0, rb2, rb3}, {16'h0, 2'b00, 8'h5c, 6'h00});
        // every channel, both polarities
        for (int i = 0; i < 8; i++)
        begin
            lv = 8'h11 * i[7:0] + 8'h03;
            ctl = {1'b1, i[2:0], i[0], i[0], 2'b11};
            ext_conv(lv, ctl, i[0] ? lv : lv ^ 8'h80, i == 0);
        end
        // 16 clocks a conversion: next start only counts after the msb
        apb(1'b1, 12'h000, 32'h9a, rd, e);
        host.sel(1'b0);
        host.xfer(8'hff, rb1);
        host.xfer(8'h00, rb2);
        host.xfer(8'h93, rb3);
        cmp({16'h0, rb2, rb3}, {16'h0, 2'b00, 8'h9a, 6'h00});
        host.xfer(8'h00, rb2);
        host.xfer(8'h00, rb3);
        host.sel(1'b1);
        cmp({16'h0, rb2, rb3}, {16'h0, 2'b00, 8'h1a, 6'h00});
        // select toggled mid-conversion, then a new start
        host.sel(1'b0);
        host.xfer(8'hae, rb1);
        host.sel(1'b1);
        ext_conv(8'h34, 8'hbf, 8'h34, 1'b0);
        // shutdown kills a running conversion for good
        host.sel(1'b0);
        host.xfer(8'hae, rb1);
        repeat (20) @(posedge ref_clk);
        shutdown_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        apb(1'b0, 12'h004, 32'h0, rd, e);
        cmp(rd, {8'h00, 8'hae, 6'h00, 2'b00, 8'h34});
        shutdown_n <= 1'b1;
        repeat (CONV + 16) @(posedge ref_clk);
        cmp({30'h0, strobe_oe, conversion_strobe}, 32'h2);
        results();
    end
endmodule : testbench
`default_nettype wire
